//--- design/wdw_watchdog.sv
// Windowed watchdog unit with APB register slave and tick divider
`timescale 1ns/10ps
`default_nettype none

module wdw_watchdog #(
    parameter longint TICK_CYCLES = wdw_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        SRST,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // CPU side
    input  wire logic        WATCHDOG_CLEAR_INSTRUCTION,
    input  wire logic        CHANGE_PROTECTION_OPEN,
    input  wire logic        DEBUG_MODE,
    input  wire logic        DEBUG_HALT,
    // Boot configuration
    input  wire logic [7:0]  BOOT_CONFIG_FUSE,
    // System reset request
    output logic             SYS_RESET_REQ
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Tick count for a timeout code; reserved and zero codes give zero
    function automatic logic [13:0] code_len(input logic [3:0] code);
        logic [13:0] len;
        len = 14'h0000;
        if ((code != 4'h0) && (code <= wdw_pkg::CODE_MAX))
        begin
            len = 14'h0001 << (code + 4'h2);
        end
        return len;
    endfunction

    localparam logic [16:0] DIV_LAST = 17'(TICK_CYCLES - 1);

    wdw_pkg::wdw_state_s s_q;
    wdw_pkg::wdw_state_s s_d;

    logic        setup;
    logic        access;
    logic [5:0]  idx;
    logic        mapped;
    logic        ctrl_wr_ok;
    logic        stat_wr;
    logic [13:0] open_len;
    logic [13:0] closed_len;
    logic        enabled;
    logic        winmode;
    logic [13:0] cnt_nx;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------

    // Bus phases and address decode
    assign setup      = PSEL && !PENABLE;
    assign access     = PSEL && PENABLE && s_q.pready;
    assign idx        = PADDR[7:2];
    assign mapped     = (PADDR[1:0] == 2'h0) && ((idx == wdw_pkg::WATCHDOG_CONTROL_IDX)
                        || (idx == wdw_pkg::WATCHDOG_STATUS_IDX));
    // Control accepted only when unlocked by key, not locked and not busy
    assign ctrl_wr_ok = access && PWRITE && (idx == wdw_pkg::WATCHDOG_CONTROL_IDX)
                        && mapped && CHANGE_PROTECTION_OPEN
                        && !s_q.lock && !s_q.busy;
    assign stat_wr    = access && PWRITE && mapped && (idx == wdw_pkg::WATCHDOG_STATUS_IDX)
                        && CHANGE_PROTECTION_OPEN;

    // Counter view of the configuration
    assign open_len   = code_len(s_q.act[wdw_pkg::PERIOD_LSB +: 4]);
    assign closed_len = code_len(s_q.act[wdw_pkg::WINDOW_LSB +: 4]);
    assign enabled    = open_len != 14'h0000;
    assign winmode    = closed_len != 14'h0000;
    assign cnt_nx     = s_q.cnt + 14'h0001;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    // All state updates in one place
    always_comb
    begin
        s_d       = s_q;
        s_d.tick  = 1'b0;

        // Tick divider; the only slow rate in the block
        if (s_q.div == DIV_LAST)
        begin
            s_d.div  = 17'h00000;
            s_d.tick = 1'b1;
        end
        else
        begin
            s_d.div = s_q.div + 17'h00001;
        end

        // Fuse load one cycle after reset release; a port is never a reset value
        if (!s_q.booted)
        begin
            s_d.booted = 1'b1;
            s_d.ctrl   = BOOT_CONFIG_FUSE;
            s_d.act    = BOOT_CONFIG_FUSE;
            s_d.lock   = BOOT_CONFIG_FUSE[wdw_pkg::PERIOD_LSB +: 4] != 4'h0;
        end

        // APB: answer in the cycle after setup
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        if (setup && !s_q.pready)
        begin
            s_d.pready  = 1'b1;
            s_d.pslverr = !mapped;
            s_d.prdata  = 32'h00000000;
            if (mapped && (idx == wdw_pkg::WATCHDOG_CONTROL_IDX))
            begin
                s_d.prdata[7:0] = s_q.ctrl;
            end
            else if (mapped)
            begin
                s_d.prdata[wdw_pkg::LOCK_BIT] = s_q.lock;
                s_d.prdata[wdw_pkg::SYNC_BIT] = s_q.busy;
            end
        end

        // Control write starts a crossing into the tick domain
        if (ctrl_wr_ok)
        begin
            s_d.ctrl     = PWDATA[7:0];
            s_d.busy     = 1'b1;
            s_d.busy_cnt = 2'h0;
        end

        // Lock: set freely, cleared only under debug; busy bit ignores writes
        if (stat_wr && PWDATA[wdw_pkg::LOCK_BIT])
        begin
            s_d.lock = 1'b1;
        end
        else if (stat_wr && DEBUG_MODE)
        begin
            s_d.lock = 1'b0;
        end

        // A clear arriving while one is pending merges with it, except on the completing tick, where it starts a new pending clear
        if (WATCHDOG_CLEAR_INSTRUCTION && !s_q.clr_pend)
        begin
            s_d.clr_pend = 1'b1;
            s_d.clr_cnt  = 2'h0;
        end

        // Tick-domain work, no dependence on CPU sleep state
        if (s_q.tick && s_q.booted)
        begin
            if (s_q.busy)
            begin
                s_d.busy_cnt = s_q.busy_cnt + 2'h1;
                if (s_q.busy_cnt + 2'h1 == wdw_pkg::SYNC_TICKS)
                begin
                    s_d.busy = 1'b0;
                    s_d.act  = s_q.ctrl;
                    // New config disarms the closed window; the count restarts only if the old config was disabled, else it counts on
                    s_d.cnt    = 14'h0000;
                    s_d.closed = 1'b0;
                end
            end

            if (DEBUG_HALT)
            begin
                s_d.cnt      = 14'h0000;
                s_d.closed   = 1'b0;
                s_d.clr_pend = 1'b0;
            end
            else if (s_q.clr_pend && (s_q.clr_cnt + 2'h1 == wdw_pkg::SYNC_TICKS))
            begin
                s_d.clr_pend = WATCHDOG_CLEAR_INSTRUCTION;
                s_d.clr_cnt  = 2'h0;
                if (enabled && s_q.closed)
                begin
                    s_d.rst_req = 1'b1;
                end
                s_d.cnt    = 14'h0000;
                s_d.closed = enabled && winmode;
            end
            else if (enabled)
            begin
                if (s_q.clr_pend)
                begin
                    s_d.clr_cnt = s_q.clr_cnt + 2'h1;
                end
                s_d.cnt = cnt_nx;
                if (s_q.closed && (cnt_nx == closed_len))
                begin
                    s_d.cnt    = 14'h0000;
                    s_d.closed = 1'b0;
                end
                else if (!s_q.closed && (cnt_nx == open_len))
                begin
                    s_d.rst_req = 1'b1;
                end
            end
            else if (s_q.clr_pend)
            begin
                s_d.clr_cnt = s_q.clr_cnt + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Synchronous reset to constants only
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign PRDATA        = s_q.prdata;
    assign PREADY        = s_q.pready;
    assign PSLVERR       = s_q.pslverr;
    assign SYS_RESET_REQ = s_q.rst_req;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SRST);

    sequence ctrl_write_s;
        ctrl_wr_ok;
    endsequence

    sequence sync_done_s;
        s_q.tick && s_q.busy && (s_q.busy_cnt == 2'h1);
    endsequence

    sequence early_clear_s;
        s_q.tick && s_q.clr_pend && (s_q.clr_cnt == 2'h1) && s_q.closed && enabled
            && !DEBUG_HALT;
    endsequence

    reset_sticky_a: assert property (s_q.rst_req |=> s_q.rst_req)
        else $error("system reset request dropped");

    lock_clear_a: assert property ($fell(s_q.lock) |-> $past(DEBUG_MODE))
        else $error("lock cleared outside debug mode");

    locked_hold_a: assert property (s_q.booted && s_q.lock && access && PWRITE
        |=> $stable(s_q.ctrl))
        else $error("locked control register changed");

    no_key_a: assert property (s_q.booted && access && !CHANGE_PROTECTION_OPEN
        |=> $stable(s_q.ctrl) && $stable(s_q.lock))
        else $error("protected register changed without unlock");

    busy_span_a: assert property (ctrl_write_s |=> s_q.busy)
        else $error("busy flag not raised by control write");

    // Busy may only drop on the tick that finishes the crossing
    busy_hold_a: assert property (s_q.busy && !(s_q.tick && (s_q.busy_cnt == 2'h1))
        |=> s_q.busy)
        else $error("busy flag dropped before crossing finished");

    sync_apply_a: assert property (sync_done_s ##1 (s_q.busy == 1'b0)
        |-> (s_q.act == $past(s_q.ctrl)))
        else $error("control value not applied after crossing");

    early_clear_a: assert property (early_clear_s |=> s_q.rst_req)
        else $error("clear in closed window did not reset");

    halt_clear_a: assert property (s_q.tick && s_q.booted && DEBUG_HALT
        |=> (s_q.cnt == 14'h0000) && !s_q.closed)
        else $error("debug halt did not reset counter");

    disabled_a: assert property (s_q.booted && !enabled && !s_q.rst_req
        |=> !s_q.rst_req)
        else $error("disabled watchdog requested reset");

    status_read_a: assert property (setup && !s_q.pready && mapped
        && (idx == wdw_pkg::WATCHDOG_STATUS_IDX) |=> (PRDATA[6:1] == 6'h00) && PREADY)
        else $error("status reserved bits not zero");

    boot_lock_a: assert property ($rose(s_q.booted)
        |-> s_q.lock == (s_q.ctrl[3:0] != 4'h0))
        else $error("boot lock does not follow fuse period");

endmodule

`default_nettype wire

//--- pkg/wdw_pkg.sv
// Package of constants and state layout for the windowed watchdog unit
package wdw_pkg;

    // ------------------------------------------------------------------
    // Register map (indices, byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0] WATCHDOG_CONTROL_IDX = 6'h00;
    localparam logic [5:0] WATCHDOG_STATUS_IDX  = 6'h01;

    // Field positions
    localparam int WINDOW_LSB   = 4;
    localparam int PERIOD_LSB   = 0;
    localparam int LOCK_BIT     = 7;
    localparam int SYNC_BIT     = 0;

    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET  = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam longint CLOCK_HZ       = 64'd100_000_000;
    localparam longint TICK_MILLIHZ   = 64'd1_024_000;
    // Longest whole count of bus clocks per watchdog tick, rounded down
    localparam longint TICK_CYCLES    = (CLOCK_HZ * 64'd1000) / TICK_MILLIHZ;
    // Ticks a control value or clear needs to cross into the tick domain
    localparam logic [1:0] SYNC_TICKS = 2'h2;
    // Highest valid timeout code (8 << 10 ticks)
    localparam logic [3:0] CODE_MAX   = 4'hb;

    // ------------------------------------------------------------------
    // Complete module state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        booted;
        logic [7:0]  ctrl;       // Bus-side watchdog_control
        logic        lock;
        logic        busy;       // sync_pending_flag
        logic [1:0]  busy_cnt;
        logic [7:0]  act;        // Control as seen by the counter
        logic [13:0] cnt;
        logic        closed;     // Counter sits in the closed window
        logic        clr_pend;
        logic [1:0]  clr_cnt;
        logic [16:0] div;
        logic        tick;
        logic        rst_req;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } wdw_state_s;

endpackage

//--- verif/wdw_cpu_model.sv
// CPU core model: APB master, clear instruction and debug levels
`timescale 1ns/10ps
`default_nettype none

module wdw_cpu_model (
    // Clock
    input  wire logic        clk,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // Core controls
    output logic             watchdog_clear_instruction,
    output logic             unlock,
    output logic             dbg_mode,
    output logic             dbg_halt
);
    // ------------------------------------------------------------------
    // Bus and core tasks
    // ------------------------------------------------------------------
    logic [31:0] rd_q;
    logic        err_q;

    // Idle bus and core at time zero
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {watchdog_clear_instruction, unlock, dbg_mode, dbg_halt} = '0;
    end

    // One transfer; the key goes in just before a protected access
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       input logic prot);
        @(posedge clk);
        unlock  <= prot;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // No assumed latency: only the bench watchdog ends a stuck wait
        while (pready !== 1'b1)
        begin
            @(posedge clk);
        end
        rd_q = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        unlock  <= 1'b0;
    endtask

    // Poll busy so no control write lands mid-crossing
    task automatic wait_idle();
        int n;
        n = 0;
        apb(1'b0, {wdw_pkg::WATCHDOG_STATUS_IDX, 2'b00}, 8'h00, 1'b0);
        while (rd_q[0] !== 1'b0 && n < 64)
        begin
            n++;
            apb(1'b0, {wdw_pkg::WATCHDOG_STATUS_IDX, 2'b00}, 8'h00, 1'b0);
        end
    endtask

    // Clear instruction as a one-cycle pulse
    task automatic clear();
        @(posedge clk);
        watchdog_clear_instruction <= 1'b1;
        @(posedge clk);
        watchdog_clear_instruction <= 1'b0;
    endtask
endmodule

`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the windowed watchdog unit
`timescale 1ns/10ps
`default_nettype none

module testbench;
    // ------------------------------------------------------------------
    // Bench setup
    // ------------------------------------------------------------------
    localparam int         T      = 8;
    localparam logic [7:0] A_CTRL = {wdw_pkg::WATCHDOG_CONTROL_IDX, 2'b00};
    localparam logic [7:0] A_STAT = {wdw_pkg::WATCHDOG_STATUS_IDX, 2'b00};

    logic        CLOCK = 1'b0;
    logic        SRST;
    logic [7:0]  fuse;
    logic        psel, penable, pwrite, pready, pslverr, rst_req;
    logic        watchdog_clear_instruction, unlock, dbg_mode, dbg_halt;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    int          fails, checks_done, n, e;

    // Short tick so timeouts fit in the run
    wdw_watchdog #(.TICK_CYCLES(T)) i_dut (.CLOCK(CLOCK), .SRST(SRST),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .WATCHDOG_CLEAR_INSTRUCTION(watchdog_clear_instruction), .CHANGE_PROTECTION_OPEN(unlock),
        .DEBUG_MODE(dbg_mode), .DEBUG_HALT(dbg_halt),
        .BOOT_CONFIG_FUSE(fuse), .SYS_RESET_REQ(rst_req));

    wdw_cpu_model i_cpu (.clk(CLOCK), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .watchdog_clear_instruction(watchdog_clear_instruction), .unlock(unlock),
        .dbg_mode(dbg_mode), .dbg_halt(dbg_halt));

    // 100 MHz clock
    always #5 CLOCK = ~CLOCK;

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Single exit of the run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Reset with a given fuse value; fuse is stable at release
    task automatic do_reset(input logic [7:0] f);
        @(posedge CLOCK);
        SRST <= 1'b1;
        fuse <= f;
        repeat (5) @(posedge CLOCK);
        SRST <= 1'b0;
    endtask

    task automatic ticks(input int k);
        repeat (k * T) @(posedge CLOCK);
    endtask

    // Protected control write after busy has dropped
    task automatic ctrl(input logic [7:0] d);
        i_cpu.wait_idle();
        i_cpu.apb(1'b1, A_CTRL, d, 1'b1);
    endtask

    // Hang guard, sized well above the expected run
    initial
    begin
        #400000;
        fails++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        SRST = 1'b1;
        fuse = 8'h00;
        fails = 0;
        checks_done = 0;
        void'($urandom(38));
        do_reset(8'h00);
        ticks(20);
        chk("reset_req_off", rst_req, 0);
        i_cpu.apb(1'b0, 8'h08, 8'h00, 1'b0);
        chk("unmapped_err", i_cpu.err_q, 1);
        chk("unmapped_data", i_cpu.rd_q, 0);
        i_cpu.apb(1'b1, A_STAT, 8'h7e, 1'b1);
        i_cpu.apb(1'b0, A_STAT, 8'h00, 1'b0);
        chk("status_spare", i_cpu.rd_q, 0);
        i_cpu.apb(1'b1, A_CTRL, 8'h03, 1'b0);
        i_cpu.apb(1'b0, A_CTRL, 8'h00, 1'b0);
        chk("ctrl_no_key", i_cpu.rd_q, 0);
        // Timeout length for each short period code
        for (int c = 1; c <= 7; c++)
        begin
            do_reset(8'h00);
            ctrl(8'(c));
            i_cpu.apb(1'b0, A_STAT, 8'h00, 1'b0);
            chk("busy_set", i_cpu.rd_q, 1);
            i_cpu.wait_idle();
            e = 1 << (c + 2);
            n = 0;
            while (rst_req !== 1'b1 && n < 8000)
            begin
                n++;
                @(posedge CLOCK);
            end
            chk("timeout_len", 32'(n >= (e - 1) * T && n <= (e + 1) * T), 1);
        end
        // Random clear spacing keeps the unit alive
        do_reset(8'h00);
        ctrl(8'h01);
        i_cpu.wait_idle();
        repeat (10)
        begin
            ticks($urandom_range(2, 4));
            i_cpu.clear();
        end
        chk("kept_alive", rst_req, 0);
        // Window mode: first clear free, open clear good, closed clear bad
        do_reset(8'h00);
        ctrl(8'h11);
        i_cpu.wait_idle();
        ticks(4);
        i_cpu.clear();
        ticks(11);
        chk("first_clear", rst_req, 0);
        i_cpu.clear();
        ticks(3);
        chk("open_clear", rst_req, 0);
        i_cpu.clear();
        ticks(4);
        chk("closed_clear", rst_req, 1);
        // Boot fuse starts and locks
        do_reset(8'h01);
        ticks(12);
        chk("fuse_timeout", rst_req, 1);
        i_cpu.apb(1'b0, A_STAT, 8'h00, 1'b0);
        chk("fuse_lock", i_cpu.rd_q, 32'h80);
        i_cpu.apb(1'b1, A_CTRL, 8'h05, 1'b1);
        i_cpu.apb(1'b0, A_CTRL, 8'h00, 1'b0);
        chk("locked_ctrl", i_cpu.rd_q, 1);
        i_cpu.apb(1'b1, A_STAT, 8'h00, 1'b1);
        i_cpu.apb(1'b0, A_STAT, 8'h00, 1'b0);
        chk("lock_kept", i_cpu.rd_q, 32'h80);
        i_cpu.dbg_mode <= 1'b1;
        i_cpu.apb(1'b1, A_STAT, 8'h00, 1'b1);
        i_cpu.apb(1'b0, A_STAT, 8'h00, 1'b0);
        chk("lock_debug_clr", i_cpu.rd_q, 0);
        i_cpu.dbg_mode <= 1'b0;
        // Debug halt holds and restarts the counter
        do_reset(8'h00);
        ctrl(8'h01);
        i_cpu.wait_idle();
        ticks(6);
        i_cpu.dbg_halt <= 1'b1;
        ticks(20);
        chk("halt_no_reset", rst_req, 0);
        i_cpu.dbg_halt <= 1'b0;
        ticks(5);
        chk("halt_cnt_zero", rst_req, 0);
        ticks(6);
        chk("resume_timeout", rst_req, 1);
        print_verdict();
    end
endmodule

`default_nettype wire
